// File: reset_pkg.sv
// Constants, types and register map of the reset source and flag logic.
// Assumes a single 250 MHz clock domain and an AHB-Lite register port.
package reset_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_RESET_FLAG_CONTROL = 8'h00;
    localparam logic [7:0] OFF_WATCHDOG_CONTROL = 8'h04;
    localparam logic [7:0] OFF_LOW_VOLTAGE_SELECT = 8'h08;
    localparam logic [7:0] OFF_CORE_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_PORT_CONTROL = 8'h18;
    localparam logic [7:0] OFF_PORT_DATA = 8'h1c;

    // Reset flag control fields
    localparam int RFC_SOFT_RESET_BIT = 0;
    localparam int RFC_LV_SELECT_ERR_BIT = 1;
    localparam int RFC_LV_RESET_BIT = 2;
    localparam int RFC_IDLE_CLOCK_BIT = 7;

    // Watchdog control fields
    localparam int WDC_ENABLE_LSB = 3;
    localparam int WDC_ENABLE_MSB = 7;
    localparam logic [4:0] WDC_CODE_DISABLE = 5'h15;
    localparam logic [4:0] WDC_CODE_ENABLE = 5'h0a;

    // Core status fields
    localparam int CST_TIME_OUT_BIT = 0;
    localparam int CST_POWER_DOWN_BIT = 1;

    // Interrupt status fields
    localparam int IRQ_FULL_RESET_BIT = 0;
    localparam int IRQ_WAKE_RESET_BIT = 1;
    localparam int IRQ_LV_RESET_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    // Reset values
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h53;
    localparam logic [7:0] LOW_VOLTAGE_SELECT_RESET = 8'h55;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [2:0] RFC_FLAGS_RESET = 3'h0;

    // Defined low-voltage level codes
    localparam logic [7:0] LVS_CODE_A = 8'h55;
    localparam logic [7:0] LVS_CODE_B = 8'h33;
    localparam logic [7:0] LVS_CODE_C = 8'h99;
    localparam logic [7:0] LVS_CODE_D = 8'haa;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_START_DELAY_NS = 16_700_000;
    localparam int RESET_START_CYCLES = RESET_START_DELAY_NS / CLK_PERIOD_NS;
    localparam int WAKE_FAST_RC_CLOCKS = 16;
    localparam int WAKE_CRYSTAL_CLOCKS = 1024;
    localparam int WAKE_SLOW_RC_CLOCKS = 2;
    localparam int BAD_CODE_SLOW_TICKS = 2;
    localparam int DELAY_COUNT_WIDTH = 23;

    typedef enum logic [1:0] {SRC_FAST_RC, SRC_CRYSTAL, SRC_SLOW_RC} clk_src_t;

    typedef enum {ST_FULL, ST_RUN, ST_WAKE} seq_state_t;

    typedef struct packed {
        logic lv_detect;
        logic lv_select_err;
        logic wdc_err;
        logic wdt_run;
        logic wdt_halted;
    } reset_cause_t;

endpackage

// File: slow_tick_delay.sv
// Counts low-speed RC ticks while a bad code is present and fires on each tick once TICKS ticks are counted.
// Assumes tick is a one-cycle pulse synchronous to hclk.
module slow_tick_delay
    import reset_pkg::*;
#(
    parameter int TICKS = BAD_CODE_SLOW_TICKS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic arm,
    input wire logic tick,
    output logic fire
);

    logic [3:0] count_q;

    // The first tick may come at once, so firing on the tick after TICKS whole
    // ticks lands TICKS..TICKS+1 slow periods after the bad code appears
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_q <= 4'h0;
        end
        else if (!arm)
        begin
            count_q <= 4'h0;
        end
        else if (tick && count_q < 4'(TICKS))
        begin
            count_q <= count_q + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fire <= 1'b0;
        end
        else
        begin
            fire <= arm && tick && (count_q == 4'(TICKS));
        end
    end

endmodule

// File: reset_flag_unit.sv
// Reset source merging, cause flags and per-source register initial values.
// Assumes hresetn is the power-on reset and all event inputs are hclk-synchronous.
module reset_flag_unit
    import reset_pkg::*;
#(
    parameter int START_CYCLES = RESET_START_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic low_voltage_reset,
    input wire logic wdt_timeout,
    input wire logic halted,
    input wire logic [1:0] clk_src,
    input wire logic slow_rc_tick,
    output logic core_reset_q,
    output logic pc_sp_reset_q,
    output logic wdt_clear_q,
    output logic wdt_enable_q,
    output logic time_out_flag_q,
    output logic power_down_flag_q,
    output logic idle_system_clock_keep_q,
    output logic [7:0] low_voltage_level_select_q,
    output logic [7:0] port_control_q,
    output logic [7:0] port_data_q,
    output logic irq_q
);

    seq_state_t state_q;
    logic [DELAY_COUNT_WIDTH-1:0] count_q;
    logic [DELAY_COUNT_WIDTH-1:0] wake_limit_q;
    logic [DELAY_COUNT_WIDTH-1:0] wake_limit_d;
    logic [7:0] watchdog_control_q;
    logic [2:0] rfc_flags_q;
    logic [IRQ_WIDTH-1:0] irq_status_q;
    logic [IRQ_WIDTH-1:0] irq_mask_q;
    logic [IRQ_WIDTH-1:0] irq_set;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_d;
    logic [1:0] bad_code;
    logic [1:0] bad_fire;
    reset_cause_t cause;
    logic full_go;
    logic wake_go;
    logic accept;
    logic wr_now;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign accept = hsel && hready && htrans[1];
    assign wr_now = wr_pend_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= accept && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (haddr[7:0])
            OFF_RESET_FLAG_CONTROL:
                rd_d = {24'h0, idle_system_clock_keep_q, 4'h0, rfc_flags_q};
            OFF_WATCHDOG_CONTROL:
                rd_d = {24'h0, watchdog_control_q};
            OFF_LOW_VOLTAGE_SELECT:
                rd_d = {24'h0, low_voltage_level_select_q};
            OFF_CORE_STATUS:
                rd_d = {30'h0, power_down_flag_q, time_out_flag_q};
            OFF_IRQ_STATUS:
                rd_d = {29'h0, irq_status_q};
            OFF_IRQ_MASK:
                rd_d = {29'h0, irq_mask_q};
            OFF_PORT_CONTROL:
                rd_d = {24'h0, port_control_q};
            OFF_PORT_DATA:
                rd_d = {24'h0, port_data_q};
            default:
                rd_d = 32'h0000_0000;
        endcase
    end

    // Read data is sampled at the address phase; back-to-back write then read
    // of one register would see the old value, which single transfers never do
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (accept && !hwrite)
        begin
            hrdata <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset source detection

    assign bad_code[0] = (watchdog_control_q[WDC_ENABLE_MSB:WDC_ENABLE_LSB] != WDC_CODE_ENABLE)
        && (watchdog_control_q[WDC_ENABLE_MSB:WDC_ENABLE_LSB] != WDC_CODE_DISABLE);
    assign bad_code[1] = (low_voltage_level_select_q != LVS_CODE_A)
        && (low_voltage_level_select_q != LVS_CODE_B)
        && (low_voltage_level_select_q != LVS_CODE_C)
        && (low_voltage_level_select_q != LVS_CODE_D);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_bad_delay
            slow_tick_delay #(
                .TICKS(BAD_CODE_SLOW_TICKS)
            ) u_delay (
                .hclk(hclk),
                .hresetn(hresetn),
                .arm(bad_code[gi] && state_q != ST_FULL),
                .tick(slow_rc_tick),
                .fire(bad_fire[gi])
            );
        end
    endgenerate

    // Sources are ignored while the full reset is already being held
    always_comb
    begin
        cause = '0;
        if (state_q != ST_FULL)
        begin
            cause.lv_detect = low_voltage_reset;
            cause.lv_select_err = bad_fire[1];
            cause.wdc_err = bad_fire[0];
            cause.wdt_run = wdt_timeout && !halted;
            cause.wdt_halted = wdt_timeout && halted;
        end
    end

    assign full_go = cause.lv_detect || cause.lv_select_err || cause.wdc_err
        || cause.wdt_run;
    assign wake_go = cause.wdt_halted && !full_go;

    always_comb
    begin
        case (clk_src_t'(clk_src))
            SRC_CRYSTAL:
                wake_limit_d = DELAY_COUNT_WIDTH'(WAKE_CRYSTAL_CLOCKS);
            SRC_SLOW_RC:
                wake_limit_d = DELAY_COUNT_WIDTH'(WAKE_SLOW_RC_CLOCKS);
            default:
                wake_limit_d = DELAY_COUNT_WIDTH'(WAKE_FAST_RC_CLOCKS);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_FULL;
            count_q <= '0;
            wake_limit_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_FULL:
                begin
                    if (count_q >= DELAY_COUNT_WIDTH'(START_CYCLES - 1))
                    begin
                        state_q <= ST_RUN;
                        count_q <= '0;
                    end
                    else
                    begin
                        count_q <= count_q + 1'b1;
                    end
                end
                ST_RUN, ST_WAKE:
                begin
                    if (full_go)
                    begin
                        state_q <= ST_FULL;
                        count_q <= '0;
                    end
                    else if (wake_go)
                    begin
                        state_q <= ST_WAKE;
                        count_q <= '0;
                        wake_limit_q <= wake_limit_d;
                    end
                    else if (state_q == ST_WAKE && count_q >= wake_limit_q - 1'b1)
                    begin
                        state_q <= ST_RUN;
                        count_q <= '0;
                    end
                    else if (state_q == ST_WAKE)
                    begin
                        count_q <= count_q + 1'b1;
                    end
                end
                default:
                begin
                    state_q <= ST_FULL;
                    count_q <= '0;
                end
            endcase
        end
    end

    // Core reset holds PC at zero, interrupts and timers off, SP at top
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            core_reset_q <= 1'b1;
            pc_sp_reset_q <= 1'b0;
            wdt_clear_q <= 1'b1;
        end
        else
        begin
            core_reset_q <= (state_q == ST_FULL && count_q < DELAY_COUNT_WIDTH'(START_CYCLES - 1))
                || full_go;
            pc_sp_reset_q <= wake_go || (state_q == ST_WAKE && !full_go
                && count_q < wake_limit_q - 1'b1);
            wdt_clear_q <= full_go || wake_go;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cause flags

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            time_out_flag_q <= 1'b0;
            power_down_flag_q <= 1'b0;
        end
        else
        begin
            if (cause.wdt_run || cause.wdt_halted)
            begin
                time_out_flag_q <= 1'b1;
            end
            if (cause.wdt_halted)
            begin
                power_down_flag_q <= 1'b1;
            end
        end
    end

    // Hardware set wins over a software write of zero in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rfc_flags_q <= RFC_FLAGS_RESET;
        end
        else
        begin
            if (wr_now && wr_addr_q == OFF_RESET_FLAG_CONTROL)
            begin
                rfc_flags_q <= hwdata[2:0];
            end
            if (cause.wdc_err)
            begin
                rfc_flags_q[RFC_SOFT_RESET_BIT] <= 1'b1;
            end
            if (cause.lv_select_err)
            begin
                rfc_flags_q[RFC_LV_SELECT_ERR_BIT] <= 1'b1;
            end
            if (cause.lv_detect)
            begin
                rfc_flags_q[RFC_LV_RESET_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers reloaded by full resets

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            watchdog_control_q <= WATCHDOG_CONTROL_RESET;
            idle_system_clock_keep_q <= 1'b0;
            port_control_q <= PORT_RESET;
            port_data_q <= PORT_RESET;
        end
        else if (full_go)
        begin
            watchdog_control_q <= WATCHDOG_CONTROL_RESET;
            idle_system_clock_keep_q <= 1'b0;
            port_control_q <= PORT_RESET;
            port_data_q <= PORT_RESET;
        end
        else if (wr_now)
        begin
            case (wr_addr_q)
                OFF_WATCHDOG_CONTROL:
                    watchdog_control_q <= hwdata[7:0];
                OFF_RESET_FLAG_CONTROL:
                    idle_system_clock_keep_q <= hwdata[RFC_IDLE_CLOCK_BIT];
                OFF_PORT_CONTROL:
                    port_control_q <= hwdata[7:0];
                OFF_PORT_DATA:
                    port_data_q <= hwdata[7:0];
                default:
                    ;
            endcase
        end
    end

    // A genuine low-voltage event or halted time-out keeps the selected level; a bad code or a run-mode time-out reloads it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_voltage_level_select_q <= LOW_VOLTAGE_SELECT_RESET;
        end
        else if (cause.lv_select_err || cause.wdc_err || cause.wdt_run)
        begin
            low_voltage_level_select_q <= LOW_VOLTAGE_SELECT_RESET;
        end
        else if (wr_now && wr_addr_q == OFF_LOW_VOLTAGE_SELECT && !full_go)
        begin
            low_voltage_level_select_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wdt_enable_q <= 1'b1;
        end
        else
        begin
            wdt_enable_q <= watchdog_control_q[WDC_ENABLE_MSB:WDC_ENABLE_LSB]
                != WDC_CODE_DISABLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, write one to clear, set wins

    assign irq_set = {cause.lv_detect, wake_go, full_go};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status_q <= '0;
            irq_mask_q <= '0;
        end
        else
        begin
            if (wr_now && wr_addr_q == OFF_IRQ_MASK)
            begin
                irq_mask_q <= hwdata[IRQ_WIDTH-1:0];
            end
            if (wr_now && wr_addr_q == OFF_IRQ_STATUS)
            begin
                irq_status_q <= (irq_status_q & ~hwdata[IRQ_WIDTH-1:0]) | irq_set;
            end
            else
            begin
                irq_status_q <= irq_status_q | irq_set;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [DELAY_COUNT_WIDTH-1:0] hold_len_h;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hold_len_h <= '0;
        end
        else
        begin
            hold_len_h <= (core_reset_q || pc_sp_reset_q) ? hold_len_h + 1'b1 : '0;
        end
    end

    chk_wdt_run_full: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_RUN && wdt_timeout && !halted) |=> core_reset_q && time_out_flag_q)
        else $error("run-mode time-out did not give full reset");

    chk_wdt_halt_part: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_RUN && wdt_timeout && halted && !full_go)
        |=> pc_sp_reset_q && !core_reset_q && $stable(watchdog_control_q))
        else $error("halted time-out did more than a PC/SP reset");

    chk_wake_length: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(pc_sp_reset_q) && !core_reset_q |-> hold_len_h == wake_limit_q)
        else $error("wake delay length wrong");

    chk_soft_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        cause.wdc_err |=> core_reset_q && rfc_flags_q[RFC_SOFT_RESET_BIT])
        else $error("bad enable code did not reset");

    chk_enable_code: assert property (@(posedge hclk) disable iff (!hresetn)
        (watchdog_control_q[WDC_ENABLE_MSB:WDC_ENABLE_LSB] == WDC_CODE_ENABLE) |=> wdt_enable_q)
        else $error("enable code did not enable watchdog");

    chk_lvr_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
        (cause.lv_detect && !wdt_timeout) |=> $stable(time_out_flag_q)
        && $stable(power_down_flag_q) && rfc_flags_q[RFC_LV_RESET_BIT])
        else $error("low-voltage reset changed flags");

    chk_halt_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        cause.wdt_halted |=> time_out_flag_q && power_down_flag_q)
        else $error("halted time-out flags not set");

    chk_lvs_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        cause.lv_select_err |=> rfc_flags_q[RFC_LV_SELECT_ERR_BIT]
        && low_voltage_level_select_q == LOW_VOLTAGE_SELECT_RESET)
        else $error("bad level code not handled");

    chk_start_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(core_reset_q) |-> hold_len_h == DELAY_COUNT_WIDTH'(START_CYCLES))
        else $error("start delay length wrong");

    chk_idle_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        full_go |=> !idle_system_clock_keep_q && watchdog_control_q == WATCHDOG_CONTROL_RESET)
        else $error("full reset did not reload registers");

endmodule

// File: reset_flag_unit_tb_top.sv
// Self-checking bench of the reset source and flag logic.
// Drives the AHB-Lite port and reset events itself; hready is the slave's hreadyout.
module reset_flag_unit_tb_top
    import reset_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short start delay keeps the run small
    localparam int START = 20;
    typedef struct packed {logic [7:0] a; logic [7:0] e;} row_t;
    row_t rows [9] = '{'{8'h00, 8'h00}, '{8'h04, 8'h53}, '{8'h08, 8'h55}, '{8'h0c, 8'h00},
        '{8'h10, 8'h00}, '{8'h14, 8'h00}, '{8'h18, 8'hff}, '{8'h1c, 8'hff}, '{8'h20, 8'h00}};
    int waits [3] = '{16, 1024, 2};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, clk_src = 2'h0;
    logic hwrite = 1'b0, low_voltage_reset = 1'b0, wdt_timeout = 1'b0, halted = 1'b0;
    logic slow_rc_tick = 1'b0, hreadyout, hresp, core_reset_q, pc_sp_reset_q, wdt_enable_q;
    logic time_out_flag_q, power_down_flag_q, idle_system_clock_keep_q, irq_q, wdt_clear_q;
    logic [7:0] low_voltage_level_select_q, port_control_q, port_data_q;
    logic [2:0] tick_cnt = 3'h0;
    int failures = 0, checked = 0, n;

    always #2 hclk = ~hclk;

    // Slow RC tick every 8 system clocks
    always @(posedge hclk)
    begin
        tick_cnt <= tick_cnt + 3'h1;
        slow_rc_tick <= (tick_cnt == 3'h7);
    end

    reset_flag_unit #(.START_CYCLES(START)) u_reset_flag_unit (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .low_voltage_reset(low_voltage_reset), .wdt_timeout(wdt_timeout),
        .halted(halted), .clk_src(clk_src), .slow_rc_tick(slow_rc_tick),
        .core_reset_q(core_reset_q), .pc_sp_reset_q(pc_sp_reset_q),
        .wdt_clear_q(wdt_clear_q),
        .wdt_enable_q(wdt_enable_q), .time_out_flag_q(time_out_flag_q),
        .power_down_flag_q(power_down_flag_q),
        .idle_system_clock_keep_q(idle_system_clock_keep_q),
        .low_voltage_level_select_q(low_voltage_level_select_q),
        .port_control_q(port_control_q), .port_data_q(port_data_q), .irq_q(irq_q));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask

    task automatic settle();
        @(posedge hclk);
        #1;
    endtask

    // Event pulse of one cycle; outputs sampled just after the edge that takes it
    task automatic ev(input logic lv);
        @(posedge hclk);
        wdt_timeout <= !lv;
        low_voltage_reset <= lv;
        @(posedge hclk);
        wdt_timeout <= 1'b0;
        low_voltage_reset <= 1'b0;
        #1;
    endtask

    task automatic hold(input logic wake, output int c);
        c = 0;
        while ((wake ? pc_sp_reset_q : core_reset_q) === 1'b1 && c < 2000)
        begin
            settle();
            c++;
        end
    endtask

    // Bad codes fire only after slow ticks, so the wait is bounded, not fixed
    task automatic wait_reset();
        n = 0;
        while (core_reset_q !== 1'b1 && n < 60)
        begin
            settle();
            n++;
        end
    endtask

    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) rdc(rows[i].a, rows[i].e);
        chk({hreadyout, hresp}, 2'b10);
        hold(1'b0, n);
        chk(port_control_q, 8'hff);
        chk(wdt_enable_q, 1'b1);
        bus(1'b1, 8'h00, 8'hff);
        rdc(8'h00, 8'h87);
        chk(idle_system_clock_keep_q, 1'b1);
        bus(1'b1, 8'h00, 8'h00);
        rdc(8'h00, 8'h00);
        bus(1'b1, 8'h04, 8'ha8);
        settle();
        chk({core_reset_q, wdt_enable_q}, 2'b00);
        bus(1'b1, 8'h04, 8'h53);
        for (int s = 0; s < 3; s++)
        begin
            bus(1'b1, 8'h1c, 8'h00);
            clk_src <= s[1:0];
            halted <= 1'b1;
            ev(1'b0);
            chk({pc_sp_reset_q, core_reset_q}, 2'b10);
            chk(wdt_clear_q, 1'b1);
            chk({time_out_flag_q, power_down_flag_q}, 2'b11);
            hold(1'b1, n);
            halted <= 1'b0;
            chk(n, waits[s]);
            chk(port_data_q, 8'h00);
        end
        bus(1'b1, 8'h08, 8'h33);
        ev(1'b0);
        chk({core_reset_q, time_out_flag_q, power_down_flag_q}, 3'b111);
        chk({port_data_q, low_voltage_level_select_q}, 16'hff55);
        hold(1'b0, n);
        chk(n, START);
        rdc(8'h10, 8'h03);
        settle();
        chk(irq_q, 1'b0);
        bus(1'b1, 8'h14, 8'h07);
        settle();
        chk(irq_q, 1'b1);
        bus(1'b1, 8'h10, 8'h07);
        settle();
        chk(irq_q, 1'b0);
        bus(1'b1, 8'h14, 8'h00);
        rdc(8'h10, 8'h00);
        bus(1'b1, 8'h08, 8'h33);
        ev(1'b1);
        chk({core_reset_q, time_out_flag_q, power_down_flag_q}, 3'b111);
        hold(1'b0, n);
        rdc(8'h00, 8'h04);
        rdc(8'h08, 8'h33);
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h04, 8'h00);
        wait_reset();
        chk(core_reset_q, 1'b1);
        chk(n >= 16 && n <= 26, 1'b1);
        hold(1'b0, n);
        rdc(8'h00, 8'h01);
        rdc(8'h04, 8'h53);
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h08, 8'h00);
        wait_reset();
        chk(core_reset_q, 1'b1);
        chk(n >= 16 && n <= 26, 1'b1);
        hold(1'b0, n);
        rdc(8'h00, 8'h02);
        rdc(8'h08, 8'h55);
        hresetn <= 1'b0;
        settle();
        chk({core_reset_q, time_out_flag_q, power_down_flag_q}, 3'b100);
        finish_test();
    end
endmodule
